// *** common/aqs_cfg.svh ***
/*
 * Register map, field positions and fixed widths of the acquisition
 * sequencer. Assumes a byte-addressed AXI4-Lite bus with 8 address bits.
 */
`ifndef AQS_CFG_SVH
`define AQS_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define AQS_ADDR_W 8
`define AQS_A_CTRL 8'h00
`define AQS_A_ENABLE 8'h04
`define AQS_A_OSCFG 8'h08
`define AQS_A_STATUS 8'h0c
`define AQS_A_IDENT 8'h10
`define AQS_A_SER_A 8'h14
`define AQS_A_SER_B 8'h18
`define AQS_A_RES_BASE 8'h40
`define AQS_A_TRIM_BASE 8'h80

// ----------------------------------------------------------------
// fields and widths
// ----------------------------------------------------------------
`define AQS_CTRL_START 0
`define AQS_ST_BUSY 0
`define AQS_ST_DONE 1
`define AQS_ST_ECC 2
`define AQS_REG_W 16
`define AQS_ADC_W 12
`define AQS_RES_W 14
`define AQS_OS_W 3
`define AQS_TRIM_N 11
`define AQS_CRC_POLY 8'h07
`define AQS_RESP_OK 2'b00
`define AQS_RESP_ERR 2'b10

`endif

// *** common/aqs_pkg.sv ***
/*
 * Types of the acquisition sequencer.
 * Assumes nothing of its surroundings.
 */
package aqs_pkg;

  typedef enum logic [2:0] {
    aqs_idle,
    aqs_seek,
    aqs_conv,
    aqs_wait,
    aqs_write
  } aqs_state_t;

endpackage

// *** rtl/aqs_trim_rom.sv ***
/*
 * Factory trim ROM: eleven 16-bit words, each stored with Hamming check
 * bits and corrected on every read. Combinational; the caller registers.
 */
`timescale 1ns/100ps
`include "aqs_cfg.svh"

module aqs_trim_rom #(
  parameter logic [10*16-1:0] TRIM_INIT = 160'h0,
  parameter logic [7:0] LAST_LOW = 8'h00,
  parameter logic [15:0] FAULT_MASK = 16'h0000
) (
  input wire logic [3:0] rd_idx_in,
  output logic [15:0] rd_data_out,
  output logic corr_out
);

  // ----------------------------------------------------------------
  // code helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] hpos(input int i);
    int c;
    hpos = 5'h00;
    c = 0;
    for (int p = 3; p < 22; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (c == i)
          hpos = 5'(p);
        c++;
      end
    end
  endfunction

  function automatic logic [4:0] hcheck(input logic [15:0] d);
    hcheck = 5'h00;
    for (int i = 0; i < 16; i++)
      if (d[i])
        hcheck = hcheck ^ hpos(i);
  endfunction

  function automatic logic [7:0] crc8(input logic [167:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 167; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? `AQS_CRC_POLY : 8'h00);
    return c;
  endfunction

  // ----------------------------------------------------------------
  // stored contents
  // ----------------------------------------------------------------
  localparam logic [15:0] LAST_WORD = {crc8({TRIM_INIT, LAST_LOW}), LAST_LOW};

  logic [15:0] word;
  logic [4:0] stored_chk;
  logic [4:0] syn;

  always_comb
  begin
    word = LAST_WORD;
    if (rd_idx_in < 4'(`AQS_TRIM_N - 1))
      word = TRIM_INIT[(`AQS_TRIM_N - 2 - 32'(rd_idx_in)) * 16 +: 16];
    stored_chk = hcheck(word);
    if (rd_idx_in == 4'h0)
      word = word ^ FAULT_MASK;
    syn = hcheck(word) ^ stored_chk;
    rd_data_out = word;
    for (int i = 0; i < 16; i++)
      if (syn != 5'h00 && hpos(i) == syn)
        rd_data_out[i] = ~word[i];
    corr_out = (syn != 5'h00);
  end

endmodule

// *** rtl/aqs_top.sv ***
/*
 * Acquisition sequencer with trim ROM and serial number, behind an
 * AXI4-Lite slave. Assumes an external 12-bit SAR converter that answers
 * each start pulse with one adc_done_in pulse and its data.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
// Operation
// - each conversion samples one selected channel; its 12-bit result accumulates
// - a scan converts every enabled channel in turn, skipping disabled ones
// - a measurement cycle is two chopped scans summed per channel
// - with oversampling, successive cycles are averaged into one value per channel
// - without oversampling an acquisition is exactly one measurement cycle
// - every software register is sixteen bits wide
// - eleven trim words are read-only; writes leave them unchanged
// - last trim word holds an 8-bit ROM checksum in bits 15:8
// - trim reads pass through error correction before being returned
// - two read-only registers form a 32-bit serial number
// - serial is unique per model and revision; host combines them
// - serial number is never zero; host treats zero as invalid
// - result is 14 bits left-aligned in 16, low two bits zero
// - disabled channels keep their previous result
`timescale 1ns/100ps
`include "aqs_cfg.svh"

module aqs_top #(
  parameter int NUM_CH = 14,
  parameter int OS_MAX = 7,
  parameter logic [31:0] SERIAL = 32'h1357_2468, // arbitrary value
  parameter logic [7:0] MODEL = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter logic [10*16-1:0] TRIM_INIT = 160'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978_8796_a5b4,
  parameter logic [7:0] TRIM_LAST_LOW = 8'h3c,
  parameter logic [15:0] TRIM_FAULT = 16'h0000
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [`AQS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`AQS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic adc_start_out,
  output logic [3:0] adc_ch_out,
  output logic adc_chop_out,
  input wire logic adc_done_in,
  input wire logic [`AQS_ADC_W-1:0] adc_data_in,
  output logic acq_done_out
);

  localparam int CH_W = $clog2(NUM_CH + 1);
  localparam int ACC_W = `AQS_ADC_W + 1 + OS_MAX;

  initial
  begin
    if (NUM_CH < 1 || NUM_CH > 16 || OS_MAX < 0 || OS_MAX > 7)
      $error("aqs_top: channel count or oversampling range unsupported");
    if (SERIAL == 32'h0000_0000)
      $error("aqs_top: serial number must not be zero");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [`AQS_ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'b00) && (a == `AQS_A_CTRL || a == `AQS_A_ENABLE || a == `AQS_A_OSCFG ||
      a == `AQS_A_STATUS || a == `AQS_A_IDENT || a == `AQS_A_SER_A || a == `AQS_A_SER_B ||
      (a >= `AQS_A_RES_BASE && 32'(a) < 32'(`AQS_A_RES_BASE) + 4 * NUM_CH) ||
      (a >= `AQS_A_TRIM_BASE && 32'(a) < 32'(`AQS_A_TRIM_BASE) + 4 * `AQS_TRIM_N));
  endfunction

  function automatic logic [CH_W-1:0] next_en(input logic [NUM_CH-1:0] en, input logic [CH_W-1:0] from);
    next_en = CH_W'(NUM_CH);
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (en[i] && i >= int'(from))
        next_en = CH_W'(i);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  aqs_pkg::aqs_state_t state_reg;
  logic [CH_W-1:0] ch_reg;
  logic [CH_W-1:0] nx_ch;
  logic scan_reg;
  logic [OS_MAX:0] cyc_reg;
  logic [NUM_CH-1:0] en_reg;
  logic [NUM_CH-1:0] en_lat_reg;
  logic [`AQS_OS_W-1:0] os_reg;
  logic [`AQS_OS_W-1:0] os_lat_reg;
  logic [ACC_W-1:0] acc_mem [NUM_CH];
  logic [`AQS_REG_W-1:0] res_mem [NUM_CH];
  logic done_st_reg;
  logic ecc_st_reg;
  logic aw_v_reg;
  logic w_v_reg;
  logic [`AQS_ADDR_W-1:0] aw_a_reg;
  logic [31:0] w_d_reg;
  logic [3:0] w_s_reg;
  logic [15:0] trim_data;
  logic trim_corr;
  logic wr_fire;
  logic start_req;
  logic [15:0] wmask;
  logic [`AQS_ADDR_W-1:0] rd_off;
  logic [`AQS_ADDR_W-1:0] res_off;

  assign nx_ch = next_en(en_lat_reg, ch_reg);
  assign wr_fire = aw_v_reg && w_v_reg && !s_axi_bvalid_out;
  assign wmask = {{8{w_s_reg[1]}}, {8{w_s_reg[0]}}};
  assign start_req = wr_fire && aw_a_reg == `AQS_A_CTRL && w_s_reg[0] && w_d_reg[`AQS_CTRL_START];
  assign rd_off = s_axi_araddr_in - `AQS_A_TRIM_BASE;
  assign res_off = s_axi_araddr_in - `AQS_A_RES_BASE;

  aqs_trim_rom #(
    .TRIM_INIT(TRIM_INIT),
    .LAST_LOW(TRIM_LAST_LOW),
    .FAULT_MASK(TRIM_FAULT)
  ) u_rom (
    .rd_idx_in(rd_off[5:2]),
    .rd_data_out(trim_data),
    .corr_out(trim_corr)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= aqs_pkg::aqs_idle;
      ch_reg <= '0;
      scan_reg <= 1'b0;
      cyc_reg <= '0;
      en_lat_reg <= '0;
      os_lat_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        aqs_pkg::aqs_idle:
          if (start_req)
          begin
            en_lat_reg <= en_reg;
            os_lat_reg <= os_reg;
            ch_reg <= '0;
            scan_reg <= 1'b0;
            cyc_reg <= '0;
            state_reg <= aqs_pkg::aqs_seek;
          end
        aqs_pkg::aqs_seek:
          if (nx_ch < CH_W'(NUM_CH))
          begin
            ch_reg <= nx_ch;
            state_reg <= aqs_pkg::aqs_conv;
          end
          else if (!scan_reg)
          begin
            scan_reg <= 1'b1;
            ch_reg <= '0;
          end
          else if (cyc_reg == (OS_MAX + 1)'((1 << os_lat_reg) - 1))
            state_reg <= aqs_pkg::aqs_write;
          else
          begin
            cyc_reg <= cyc_reg + 1'b1;
            scan_reg <= 1'b0;
            ch_reg <= '0;
          end
        aqs_pkg::aqs_conv:
          state_reg <= aqs_pkg::aqs_wait;
        aqs_pkg::aqs_wait:
          if (adc_done_in)
          begin
            ch_reg <= ch_reg + 1'b1;
            state_reg <= aqs_pkg::aqs_seek;
          end
        aqs_pkg::aqs_write:
          state_reg <= aqs_pkg::aqs_idle;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      adc_start_out <= 1'b0;
      adc_ch_out <= 4'h0;
      adc_chop_out <= 1'b0;
      acq_done_out <= 1'b0;
    end
    else
    begin
      adc_start_out <= (state_reg == aqs_pkg::aqs_conv);
      if (state_reg == aqs_pkg::aqs_conv)
      begin
        adc_ch_out <= 4'(ch_reg);
        adc_chop_out <= scan_reg;
      end
      acq_done_out <= (state_reg == aqs_pkg::aqs_write);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
        acc_mem[i] <= '0;
    end
    else if (state_reg == aqs_pkg::aqs_idle && start_req)
    begin
      for (int i = 0; i < NUM_CH; i++)
        acc_mem[i] <= '0;
    end
    else if (state_reg == aqs_pkg::aqs_wait && adc_done_in)
      acc_mem[ch_reg] <= acc_mem[ch_reg] + ACC_W'(adc_data_in);
  end

  // ----------------------------------------------------------------
  // per-channel averaging and result store
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_res
    logic [ACC_W+1:0] scaled;
    assign scaled = {acc_mem[g], 2'b00} >> ({1'b0, os_lat_reg} + 4'h1);
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
        res_mem[g] <= '0;
      else if (state_reg == aqs_pkg::aqs_write && en_lat_reg[g])
        res_mem[g] <= {scaled[`AQS_RES_W-1:0], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      aw_v_reg <= 1'b0;
      w_v_reg <= 1'b0;
      aw_a_reg <= '0;
      w_d_reg <= '0;
      w_s_reg <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `AQS_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_v_reg <= 1'b1;
        aw_a_reg <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      else if (!aw_v_reg)
        s_axi_awready_out <= 1'b1;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_v_reg <= 1'b1;
        w_d_reg <= s_axi_wdata_in;
        w_s_reg <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      else if (!w_v_reg)
        s_axi_wready_out <= 1'b1;
      if (wr_fire)
      begin
        aw_v_reg <= 1'b0;
        w_v_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= mapped(aw_a_reg) ? `AQS_RESP_OK : `AQS_RESP_ERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // writable configuration; trim, serial and results ignore writes
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      en_reg <= '0;
      os_reg <= '0;
    end
    else if (wr_fire && aw_a_reg == `AQS_A_ENABLE)
      en_reg <= (en_reg & ~NUM_CH'(wmask)) | (NUM_CH'(w_d_reg) & NUM_CH'(wmask));
    else if (wr_fire && aw_a_reg == `AQS_A_OSCFG && w_s_reg[0])
      os_reg <= (w_d_reg[`AQS_OS_W-1:0] > `AQS_OS_W'(OS_MAX)) ? `AQS_OS_W'(OS_MAX) : w_d_reg[`AQS_OS_W-1:0];
  end

  // sticky status flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      done_st_reg <= 1'b0;
      ecc_st_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == aqs_pkg::aqs_write)
        done_st_reg <= 1'b1;
      else if (wr_fire && aw_a_reg == `AQS_A_STATUS && w_s_reg[0] && w_d_reg[`AQS_ST_DONE])
        done_st_reg <= 1'b0;
      if (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in >= `AQS_A_TRIM_BASE &&
        mapped(s_axi_araddr_in) && trim_corr)
        ecc_st_reg <= 1'b1;
      else if (wr_fire && aw_a_reg == `AQS_A_STATUS && w_s_reg[0] && w_d_reg[`AQS_ST_ECC])
        ecc_st_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `AQS_RESP_OK;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= mapped(s_axi_araddr_in) ? `AQS_RESP_OK : `AQS_RESP_ERR;
      s_axi_rdata_out <= '0;
      if (mapped(s_axi_araddr_in))
      begin
        if (s_axi_araddr_in >= `AQS_A_TRIM_BASE)
          s_axi_rdata_out[15:0] <= trim_data;
        else if (s_axi_araddr_in >= `AQS_A_RES_BASE)
          s_axi_rdata_out[15:0] <= res_mem[res_off[5:2]];
        else
          unique case (s_axi_araddr_in)
            `AQS_A_CTRL: s_axi_rdata_out[`AQS_CTRL_START] <= 1'b0;
            `AQS_A_ENABLE: s_axi_rdata_out[NUM_CH-1:0] <= en_reg;
            `AQS_A_OSCFG: s_axi_rdata_out[`AQS_OS_W-1:0] <= os_reg;
            `AQS_A_STATUS: s_axi_rdata_out[2:0] <= {ecc_st_reg, done_st_reg, state_reg != aqs_pkg::aqs_idle};
            `AQS_A_IDENT: s_axi_rdata_out[15:0] <= {MODEL, REVISION};
            `AQS_A_SER_A: s_axi_rdata_out[15:0] <= SERIAL[15:0];
            `AQS_A_SER_B: s_axi_rdata_out[15:0] <= SERIAL[31:16];
            default: s_axi_rdata_out <= '0;
          endcase
      end
    end
    else if (s_axi_rvalid_out)
    begin
      if (s_axi_rready_in)
      begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
    else
      s_axi_arready_out <= 1'b1;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] conv_cnt;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      conv_cnt <= '0;
    else if (state_reg == aqs_pkg::aqs_idle && start_req)
      conv_cnt <= '0;
    else if (state_reg == aqs_pkg::aqs_wait && adc_done_in)
      conv_cnt <= conv_cnt + 16'h0001;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  conv_enabled_a: assert property (adc_start_out |-> en_lat_reg[adc_ch_out])
    else $error("conversion started on a disabled channel");
  start_single_a: assert property (adc_start_out |=> !adc_start_out)
    else $error("start pulse longer than one cycle");
  scan_skip_a: assert property (state_reg == aqs_pkg::aqs_seek && nx_ch < CH_W'(NUM_CH)
    |=> state_reg == aqs_pkg::aqs_conv && en_lat_reg[ch_reg])
    else $error("scan picked a disabled channel");
  conv_count_a: assert property (acq_done_out |->
    32'(conv_cnt) == 2 * $countones(en_lat_reg) * (1 << os_lat_reg))
    else $error("wrong number of conversions in acquisition");
  single_cycle_a: assert property (acq_done_out && os_lat_reg == '0 |->
    32'(conv_cnt) == 2 * $countones(en_lat_reg))
    else $error("acquisition without oversampling not one cycle");
  chop_order_a: assert property (adc_start_out && adc_chop_out |-> scan_reg)
    else $error("second chopped scan out of order");
  res_align_a: assert property (res_mem[0][1:0] == 2'b00)
    else $error("result low bits not zero");
  keep_disabled_a: assert property (state_reg == aqs_pkg::aqs_write && !en_lat_reg[0]
    |=> $stable(res_mem[0]))
    else $error("disabled channel result changed");
  done_after_a: assert property (state_reg == aqs_pkg::aqs_write |=> acq_done_out ##1 !acq_done_out)
    else $error("completion pulse missing");
  rdata_width_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
    else $error("upper data bits not zero");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");

  acq_os_c: cover property (acq_done_out && os_lat_reg != '0);
  acq_plain_c: cover property (acq_done_out && os_lat_reg == '0);
  trim_read_c: cover property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in >= `AQS_A_TRIM_BASE);
  write_err_c: cover property (s_axi_bvalid_out && s_axi_bresp_out == `AQS_RESP_ERR);

endmodule

// *** test/aqs_top_tb.sv ***
/*
 * Self-checking bench: registers, trim, serial number, acquisitions.
 * Assumes aqs_top alone; the bench answers each converter start itself.
 */
`timescale 1ns/100ps
`include "aqs_cfg.svh"

module aqs_top_tb;
  localparam logic [31:0] SER = 32'h1357_2468; // arbitrary value
  localparam logic [7:0] MDL = 8'h5a; // arbitrary value
  localparam logic [7:0] REV = 8'h01; // arbitrary value
  localparam logic [159:0] TINIT = 160'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978_8796_a5b4;
  localparam logic [7:0] TLOW = 8'h3c;
  localparam logic [1:0] OK = `AQS_RESP_OK;
  logic clk_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in, adc_ch_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic adc_start_out, adc_chop_out, acq_done_out;
  logic adc_done_in = 1'b0;
  logic [11:0] adc_data_in = 12'h000;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int pend = 0;
  int done_cnt = 0;
  int done_conv = 0;
  logic [4:0] cur;
  logic [4:0] seen_q[$];
  logic [15:0] exp_res[14];

  aqs_top #(.SERIAL(SER), .MODEL(MDL), .REVISION(REV), .TRIM_INIT(TINIT), .TRIM_LAST_LOW(TLOW),
    .TRIM_FAULT(16'h0010)) i_dut (
    .clk_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .adc_start_out,
    .adc_ch_out, .adc_chop_out, .adc_done_in, .adc_data_in, .acq_done_out);

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // converter stand-in and monitors
  // ----------------------------------------------------------------
  function automatic logic [11:0] conv_val(input int ch, input int chop);
    return 12'(12'h400 + ch * 32 + chop * 7);
  endfunction

  always @(posedge clk_in)
  begin
    adc_done_in <= 1'b0;
    if (adc_done_in) adc_data_in <= ~adc_data_in;
    if (adc_start_out)
    begin
      cur <= {adc_chop_out, adc_ch_out};
      pend <= adc_ch_out[0] ? 5 : 2; // odd channels answer slowly
    end
    else if (pend > 0)
    begin
      pend <= pend - 1;
      if (pend == 1)
      begin
        adc_done_in <= 1'b1;
        adc_data_in <= conv_val(cur[3:0], cur[4]);
        seen_q.push_back(cur);
      end
    end
    if (acq_done_out) done_cnt <= done_cnt + 1;
    if (acq_done_out) done_conv <= seen_q.size();
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("ERROR at %0t: timeout", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end
    while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'b0;
    chk({30'h0, s_axi_bresp_out}, {30'h0, er}, "bresp");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end
    while (!s_axi_rvalid_out);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string w);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp, w);
    chk({30'h0, r}, {30'h0, er}, w);
  endtask

  function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `AQS_CRC_POLY : 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] lo, hi;
    logic [1:0] r;
    rd_chk(`AQS_A_ENABLE, 32'h0, OK, "enable");
    rd_chk(`AQS_A_STATUS, 32'h0, OK, "status");
    rd_chk(`AQS_A_RES_BASE + 8'h14, 32'h0, OK, "result");
    rd_chk(`AQS_A_IDENT, {16'h0, MDL, REV}, OK, "ident");
    wr(`AQS_A_SER_A, 32'h0, OK);
    axi_rd(`AQS_A_SER_A, lo, r);
    axi_rd(`AQS_A_SER_B, hi, r);
    chk({hi[15:0], lo[15:0]}, SER, "serial");
    chk({hi[31:16], lo[31:16]}, 32'h0, "upper");
    chk(32'({hi[15:0], lo[15:0]} != 32'h0), 32'h1, "serial zero");
    rd_chk(8'h1c, 32'h0, `AQS_RESP_ERR, "unmapped");
    rd_chk(8'h42, 32'h0, `AQS_RESP_ERR, "unaligned");
    wr(8'h1c, 32'h1, `AQS_RESP_ERR);
    $display("test_regs done");
  endtask

  task automatic test_trim();
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 10; i++)
    begin
      for (int b = 15; b >= 0; b--) crc = crc_bit(crc, TINIT[16 * (9 - i) + b]);
      rd_chk(`AQS_A_TRIM_BASE + 8'(4 * i), {16'h0, TINIT[16 * (9 - i) +: 16]}, OK, "trim");
    end
    for (int b = 7; b >= 0; b--) crc = crc_bit(crc, TLOW[b]);
    wr(`AQS_A_TRIM_BASE + 8'h28, 32'h0000ffff, OK);
    rd_chk(`AQS_A_TRIM_BASE + 8'h28, {16'h0, crc, TLOW}, OK, "checksum");
    rd_chk(`AQS_A_STATUS, 32'h4, OK, "ecc flag");
    wr(`AQS_A_STATUS, 32'h4, OK);
    rd_chk(`AQS_A_STATUS, 32'h0, OK, "ecc clear");
    $display("test_trim done");
  endtask

  task automatic run_acq(input logic [13:0] en, input logic [2:0] os, input logic [13:0] en_next);
    logic [4:0] exp_q[$];
    int d0, acc;
    wr(`AQS_A_ENABLE, {18'h0, en}, OK);
    wr(`AQS_A_OSCFG, {29'h0, os}, OK);
    seen_q.delete();
    d0 = done_cnt;
    wr(`AQS_A_CTRL, 32'h1, OK);
    wr(`AQS_A_ENABLE, {18'h0, en_next}, OK);
    while (done_cnt == d0)
      @(posedge clk_in);
    for (int c = 0; c < (1 << os); c++)
      for (int h = 0; h < 2; h++)
        for (int ch = 0; ch < 14; ch++)
          if (en[ch]) exp_q.push_back({h[0], ch[3:0]});
    chk(32'(seen_q.size()), 32'(exp_q.size()), "conversions");
    chk(32'(done_conv), 32'(exp_q.size()), "early done");
    foreach (exp_q[i])
      if (i < seen_q.size()) chk({27'h0, seen_q[i]}, {27'h0, exp_q[i]}, "order");
    for (int ch = 0; ch < 14; ch++)
    begin
      if (en[ch])
      begin
        acc = (1 << os) * (conv_val(ch, 0) + conv_val(ch, 1));
        exp_res[ch] = {14'((acc * 4) >> (os + 1)), 2'b00};
      end
      rd_chk(`AQS_A_RES_BASE + 8'(4 * ch), {16'h0, exp_res[ch]}, OK, "result");
    end
    rd_chk(`AQS_A_STATUS, 32'h2, OK, "done flag");
    wr(`AQS_A_STATUS, 32'h2, OK);
    chk(32'(done_cnt), 32'(d0 + 1), "done pulses");
    $display("acquisition done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    sys_rst_in = 1'b1;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hf;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
    foreach (exp_res[i]) exp_res[i] = 16'h0000;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    test_regs();
    test_trim();
    run_acq(14'h2005, 3'd0, 14'h0003);
    run_acq(14'h0003, 3'd2, 14'h3fff);
    run_acq(14'h0000, 3'd1, 14'h0000);
    wrap_up();
  end
endmodule
